// >>> logic/recorder_pkg.sv
package recorder_pkg;

	// ----------------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS  = 50;
	localparam int SAMPLE_PERIOD_NS = 62_500;
	localparam int TICK_CYCLES      = SAMPLE_PERIOD_NS / CLOCK_PERIOD_NS;
	localparam logic [10:0] TICK_LAST = 11'(TICK_CYCLES - 1);

	// ----------------------------------------------------------------------
	// Capture buffer
	// ----------------------------------------------------------------------
	localparam int SAMPLE_W = 16;
	localparam int PTR_W    = 8;
	localparam logic [8:0]  CAPTURE_DEPTH = 9'h100;
	localparam logic [15:0] PERCENT_FULL  = 16'h0064;
	localparam logic signed [15:0] TEST_SAW_MAX = 16'sh0009;

	// ----------------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------------
	localparam logic [7:0] OFF_CONTROL    = 8'h00;
	localparam logic [7:0] OFF_THRESHOLD  = 8'h04;
	localparam logic [7:0] OFF_PERCENT    = 8'h08;
	localparam logic [7:0] OFF_DECIMATION = 8'h0c;
	localparam logic [7:0] OFF_COUNT      = 8'h10;
	localparam logic [7:0] OFF_COMMAND    = 8'h14;
	localparam logic [7:0] OFF_STATUS     = 8'h18;
	localparam logic [7:0] OFF_READOUT    = 8'h1c;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int CTRL_KIND_LSB     = 0;
	localparam int CTRL_POLARITY_BIT = 2;
	localparam int CTRL_SOURCE_BIT   = 3;
	localparam int CMD_ARM_BIT       = 0;
	localparam int STAT_ARMED_BIT    = 0;
	localparam int STAT_POST_BIT     = 1;
	localparam int STAT_DONE_BIT     = 2;
	localparam int STAT_TRIG_BIT     = 3;
	localparam int STAT_LEFT_LSB     = 16;

	// ----------------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------------
	localparam logic [1:0]  KIND_RESET       = 2'h0;
	localparam logic        POLARITY_RESET   = 1'h0;
	localparam logic        SOURCE_RESET     = 1'h0;
	localparam logic [15:0] THRESHOLD_RESET  = 16'h0000;
	localparam logic [6:0]  PERCENT_RESET    = 7'h00;
	localparam logic [15:0] DECIMATION_RESET = 16'h0001;
	localparam logic [8:0]  COUNT_RESET      = 9'h100;

	// ----------------------------------------------------------------------
	// Codes
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {
		KIND_IMMEDIATE = 2'h0,
		KIND_COMMAND   = 2'h1,
		KIND_THRESHOLD = 2'h2,
		KIND_BOOLEAN   = 2'h3
	} trigger_kind_t;

	localparam logic POLARITY_POSITIVE = 1'h1;

endpackage : recorder_pkg

// >>> logic/sample_recorder_trigger.sv
// How it works
// - Four trigger kinds, codes zero to three.
// - Kind zero captures at once on arming.
// - Kind one triggers on next host command.
// - Kind two triggers on threshold with slope.
// - Kind three triggers on single-bit level.
// - Percent of samples placed before trigger.
// - Immediate kind keeps no pretrigger samples.
// - Threshold used only in threshold kind.
// - Polarity one positive, zero negative.
// - Positive: previous below, current at/above threshold.
// - Negative: previous above, current at/below threshold.
// - Boolean kind is a pure level condition.
// - Level already present at arm triggers immediately.
// - With pretrigger, evaluate once per decimation.
// - Zero percent evaluates on every drive sample.
// - Length is sample count and decimation.
// - Readout returns bare sample values only.
// - Base sample tick is 1/16000 second.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns

module sample_recorder_trigger (
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [15:0] CURRENT_FEEDBACK_VALUE,
	input  wire logic        DRIVE_ACTIVE,
	output logic             CAPTURE_DONE,
	output logic             TRIGGERED
);

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_POST, ST_DONE} phase_t;

	typedef struct packed {
		phase_t             phase;
		logic [1:0]         kind;
		logic               polarity;
		logic               src_sel;
		logic signed [15:0] threshold;
		logic [6:0]         percent;
		logic [15:0]        decimation;
		logic [8:0]         count;
		logic [15:0]        fb_meta;
		logic [15:0]        fb_sync;
		logic               act_meta;
		logic               act_sync;
		logic [10:0]        tick_cnt;
		logic               tick;
		logic [15:0]        gap_cnt;
		logic signed [15:0] saw;
		logic signed [15:0] prev;
		logic               prev_valid;
		logic [8:0]         pre_cnt;
		logic [8:0]         post_left;
		logic [8:0]         read_left;
		logic [7:0]         wr_ptr;
		logic [7:0]         rd_ptr;
		logic               triggered;
		logic               done;
		logic [31:0]        prdata;
		logic               pready;
		logic               pslverr;
	} state_t;

	state_t             s_q;
	state_t             s_d;
	logic [15:0]        mem [0:255];
	logic               mem_we;
	logic signed [15:0] source;
	logic [8:0]         eff_count;
	logic [6:0]         eff_pct;
	logic [15:0]        product;
	logic [8:0]         pre_need;
	logic [8:0]         post_need;
	logic [15:0]        gap;
	logic               record;
	logic               evaluate;
	logic               hit;
	logic               fire;
	logic               in_post;
	logic [8:0]         left;
	logic               setup;
	logic               xfer;
	logic               host_cmd;
	logic               arm;

	// ----------------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		mem_we = 1'b0;

		// Both inputs come from the drive's other clocking and are synchronised.
		// The value bus may tear for one sample; a trigger compare tolerates it.
		s_d.fb_meta = CURRENT_FEEDBACK_VALUE;
		s_d.fb_sync = s_q.fb_meta;
		s_d.act_meta = DRIVE_ACTIVE;
		s_d.act_sync = s_q.act_meta;

		// The base tick runs free and arming does not realign it, so the first
		// sample after an arm comes up to one tick period later.
		s_d.tick = (s_q.tick_cnt == recorder_pkg::TICK_LAST);
		s_d.tick_cnt = s_d.tick ? 11'h000 : s_q.tick_cnt + 11'h001;
		if (s_q.tick) begin
			s_d.saw = (s_q.saw >= recorder_pkg::TEST_SAW_MAX) ? 16'sh0000 : s_q.saw + 16'sh0001;
		end

		// Out-of-range settings are folded here, so the counters below never wait
		// for a length or a share that the buffer cannot reach.
		eff_count = (s_q.count == 9'h000 || s_q.count > recorder_pkg::CAPTURE_DEPTH) ?
			recorder_pkg::CAPTURE_DEPTH : s_q.count;
		eff_pct = (16'(s_q.percent) > recorder_pkg::PERCENT_FULL) ?
			7'(recorder_pkg::PERCENT_FULL) : s_q.percent;
		if (s_q.kind == recorder_pkg::KIND_IMMEDIATE) begin
			eff_pct = 7'h00;
		end
		product = 16'(eff_count) * 16'(eff_pct);
		pre_need = 9'(product / recorder_pkg::PERCENT_FULL);
		post_need = eff_count - pre_need;
		gap = (s_q.decimation == 16'h0000) ? 16'h0001 : s_q.decimation;

		// Judging follows the decimation only while a pretrigger share is kept;
		// without one every tick is judged, so short events are not missed.
		record = s_q.tick && (s_q.gap_cnt == 16'h0000);
		evaluate = s_q.tick && ((eff_pct == 7'h00) || record);
		source = s_q.src_sel ? s_q.saw : $signed(s_q.fb_sync);

		// A crossing needs an earlier judged sample, so the first judgement after
		// arming only primes the previous value.
		hit = 1'b0;
		case (s_q.kind)
			recorder_pkg::KIND_THRESHOLD: begin
				if (s_q.polarity == recorder_pkg::POLARITY_POSITIVE) begin
					hit = s_q.prev_valid && (s_q.prev < s_q.threshold)
						&& (source >= s_q.threshold);
				end else begin
					hit = s_q.prev_valid && (s_q.prev > s_q.threshold)
						&& (source <= s_q.threshold);
				end
			end
			recorder_pkg::KIND_BOOLEAN: begin
				hit = (s_q.act_sync == s_q.polarity);
			end
			default: begin
				hit = 1'b0;
			end
		endcase

		// ------------------------------------------------------------------
		// APB slave: zero wait states, answer registered in the setup cycle
		// ------------------------------------------------------------------
		setup = PSEL && !PENABLE;
		xfer = PSEL && PENABLE && s_q.pready;
		host_cmd = xfer;
		arm = xfer && PWRITE && (PADDR == recorder_pkg::OFF_COMMAND)
			&& PWDATA[recorder_pkg::CMD_ARM_BIT];

		s_d.pready = setup;
		if (setup) begin
			s_d.prdata = 32'h0000_0000;
			s_d.pslverr = 1'b0;
			case (PADDR)
				recorder_pkg::OFF_CONTROL: begin
					s_d.prdata[recorder_pkg::CTRL_KIND_LSB +: 2] = s_q.kind;
					s_d.prdata[recorder_pkg::CTRL_POLARITY_BIT] = s_q.polarity;
					s_d.prdata[recorder_pkg::CTRL_SOURCE_BIT] = s_q.src_sel;
				end
				recorder_pkg::OFF_THRESHOLD: s_d.prdata[15:0] = s_q.threshold;
				recorder_pkg::OFF_PERCENT: s_d.prdata[6:0] = s_q.percent;
				recorder_pkg::OFF_DECIMATION: s_d.prdata[15:0] = s_q.decimation;
				recorder_pkg::OFF_COUNT: s_d.prdata[8:0] = s_q.count;
				recorder_pkg::OFF_COMMAND: s_d.prdata = 32'h0000_0000;
				recorder_pkg::OFF_STATUS: begin
					s_d.prdata[recorder_pkg::STAT_ARMED_BIT] = (s_q.phase == ST_ARMED);
					s_d.prdata[recorder_pkg::STAT_POST_BIT] = (s_q.phase == ST_POST);
					s_d.prdata[recorder_pkg::STAT_DONE_BIT] = s_q.done;
					s_d.prdata[recorder_pkg::STAT_TRIG_BIT] = s_q.triggered;
					s_d.prdata[recorder_pkg::STAT_LEFT_LSB +: 9] = s_q.read_left;
				end
				recorder_pkg::OFF_READOUT: begin
					if (s_q.phase == ST_DONE) begin
						s_d.prdata = {{16{mem[s_q.rd_ptr][15]}}, mem[s_q.rd_ptr]};
					end
				end
				default: s_d.pslverr = 1'b1;
			endcase
		end else begin
			s_d.pslverr = 1'b0;
		end

		// Writes land only at the access edge, so an abandoned setup cycle
		// leaves every setting as it was.
		if (xfer && PWRITE) begin
			case (PADDR)
				recorder_pkg::OFF_CONTROL: begin
					s_d.kind = PWDATA[recorder_pkg::CTRL_KIND_LSB +: 2];
					s_d.polarity = PWDATA[recorder_pkg::CTRL_POLARITY_BIT];
					s_d.src_sel = PWDATA[recorder_pkg::CTRL_SOURCE_BIT];
				end
				recorder_pkg::OFF_THRESHOLD: s_d.threshold = PWDATA[15:0];
				recorder_pkg::OFF_PERCENT: s_d.percent = PWDATA[6:0];
				recorder_pkg::OFF_DECIMATION: s_d.decimation = PWDATA[15:0];
				recorder_pkg::OFF_COUNT: s_d.count = PWDATA[8:0];
				default: begin
				end
			endcase
		end

		// ------------------------------------------------------------------
		// Capture sequence
		// ------------------------------------------------------------------
		// The decimation phase restarts at every arm, so the first tick records.
		if (s_q.tick && (s_q.phase == ST_ARMED || s_q.phase == ST_POST)) begin
			s_d.gap_cnt = (s_q.gap_cnt >= gap - 16'h0001) ? 16'h0000 : s_q.gap_cnt + 16'h0001;
		end

		// A trigger is refused until the pretrigger share is stored, so the
		// samples ahead of the trigger instant are always the requested number.
		fire = 1'b0;
		if (s_q.phase == ST_ARMED && s_q.pre_cnt >= pre_need) begin
			if (s_q.kind == recorder_pkg::KIND_COMMAND) begin
				fire = host_cmd;
			end else begin
				fire = evaluate && hit;
			end
		end
		in_post = (s_q.phase == ST_POST) || (fire && post_need != 9'h000);
		left = (s_q.phase == ST_POST) ? s_q.post_left : post_need;

		case (s_q.phase)
			ST_ARMED, ST_POST: begin
				if (s_q.phase == ST_ARMED && evaluate) begin
					s_d.prev = source;
					s_d.prev_valid = 1'b1;
				end
				if (record) begin
					mem_we = 1'b1;
					s_d.wr_ptr = s_q.wr_ptr + 8'h01;
					if (!in_post && s_q.pre_cnt < pre_need) begin
						s_d.pre_cnt = s_q.pre_cnt + 9'h001;
					end
				end
				if (fire) begin
					s_d.triggered = 1'b1;
				end
				if (in_post) begin
					s_d.phase = ST_POST;
					s_d.post_left = left - {8'h00, record};
				end
				// Stop once the last post sample is stored, keeping the newest
				// pretrigger samples that still fit the requested length, read out oldest first.
				if ((in_post && s_d.post_left == 9'h000) || (fire && !in_post)) begin
					s_d.phase = ST_DONE;
					s_d.done = 1'b1;
					s_d.rd_ptr = s_d.wr_ptr - eff_count[7:0];
					s_d.read_left = eff_count;
				end
			end
			ST_DONE: begin
				// Each completed readout moves on one sample; the last frees the buffer.
				if (xfer && !PWRITE && PADDR == recorder_pkg::OFF_READOUT) begin
					s_d.rd_ptr = s_q.rd_ptr + 8'h01;
					s_d.read_left = s_q.read_left - 9'h001;
					if (s_q.read_left == 9'h001) begin
						s_d.phase = ST_IDLE;
						s_d.done = 1'b0;
					end
				end
			end
			ST_IDLE: begin
			end
			default: begin
				s_d.phase = ST_IDLE;
			end
		endcase

		// Arming wins over everything else and restarts a running capture.
		if (arm) begin
			s_d.gap_cnt = 16'h0000;
			s_d.wr_ptr = 8'h00;
			s_d.pre_cnt = 9'h000;
			s_d.prev_valid = 1'b0;
			s_d.done = 1'b0;
			s_d.read_left = 9'h000;
			if (s_q.kind == recorder_pkg::KIND_IMMEDIATE) begin
				s_d.phase = ST_POST;
				s_d.post_left = eff_count;
				s_d.triggered = 1'b1;
			end else begin
				s_d.phase = ST_ARMED;
				s_d.triggered = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------------
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			s_q <= '0;
			s_q.phase <= ST_IDLE;
			s_q.kind <= recorder_pkg::KIND_RESET;
			s_q.polarity <= recorder_pkg::POLARITY_RESET;
			s_q.src_sel <= recorder_pkg::SOURCE_RESET;
			s_q.threshold <= recorder_pkg::THRESHOLD_RESET;
			s_q.percent <= recorder_pkg::PERCENT_RESET;
			s_q.decimation <= recorder_pkg::DECIMATION_RESET;
			s_q.count <= recorder_pkg::COUNT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// The sample store has no reset; its contents mean nothing until a capture ends.
	always_ff @(posedge CLOCK) begin
		if (mem_we) begin
			mem[s_q.wr_ptr] <= source;
		end
	end

	// Every output is a register bit, so no pin depends on the bus inputs.
	assign PRDATA = s_q.prdata;
	assign PREADY = s_q.pready;
	assign PSLVERR = s_q.pslverr;
	assign CAPTURE_DONE = s_q.done;
	assign TRIGGERED = s_q.triggered;

endmodule : sample_recorder_trigger

// >>> verification/recorder_assertions.sv
`timescale 1ns/1ns

module recorder_assertions (
	input wire logic        CLOCK,
	input wire logic        RST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic [15:0] CURRENT_FEEDBACK_VALUE,
	input wire logic        DRIVE_ACTIVE,
	input wire logic        CAPTURE_DONE,
	input wire logic        TRIGGERED
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	// ------------------------------------------------------------------
	// Bus steps
	// ------------------------------------------------------------------
	sequence setup_s;
		PSEL && !PENABLE;
	endsequence
	sequence arm_s;
		PSEL && PENABLE && PREADY && PWRITE && PADDR == recorder_pkg::OFF_COMMAND && PWDATA[0];
	endsequence

	a_ready_after_setup: assert property (setup_s |=> PREADY)
		else $error("no access cycle after setup");
	a_ready_one_cycle: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	a_ready_when_idle: assert property (!PSEL |=> !PREADY)
		else $error("ready without a transfer");
	a_error_reads_zero: assert property (PSLVERR |-> PREADY && (PWRITE || PRDATA == 32'h0))
		else $error("bad error response");
	a_rdata_held: assert property (!PSEL |=> $stable(PRDATA))
		else $error("read data moved while idle");
	a_done_needs_trig: assert property (CAPTURE_DONE |-> TRIGGERED)
		else $error("capture done without trigger");
	a_done_holds: assert property (CAPTURE_DONE && !PSEL |=> CAPTURE_DONE)
		else $error("buffer released without host access");
	a_trig_holds: assert property (TRIGGERED && !PSEL |=> TRIGGERED)
		else $error("trigger flag dropped without arming");
	a_arm_restarts: assert property (arm_s |=> !CAPTURE_DONE)
		else $error("arming left capture done");
endmodule : recorder_assertions

// >>> verification/recorder_host.sv
`timescale 1ns/1ns

module recorder_host (
	input  wire logic        clock,
	output logic             psel = 1'b0,
	output logic             penable = 1'b0,
	output logic             pwrite = 1'b0,
	output logic [7:0]       paddr = 8'h00,
	output logic [31:0]      pwdata = 32'h0,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Host holds the request until ready is seen; ok stays low if it never comes.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output logic ok);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		r = prdata;
		e = pslverr;
		ok = pready;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask : xfer
endmodule : recorder_host

// >>> verification/tb_sample_recorder_trigger.sv
`timescale 1ns/1ns

module tb_sample_recorder_trigger;
	localparam int T = recorder_pkg::TICK_CYCLES;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        psel, penable, pwrite, pready, pslverr, done, trig;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, got, first;
	logic [15:0] fb = 16'hff00;
	logic        act = 1'b1;
	int          error_cnt = 0;
	int          tests_run = 0;

	initial begin
		forever #25 clock = ~clock;
	end

	sample_recorder_trigger uut (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CURRENT_FEEDBACK_VALUE(fb), .DRIVE_ACTIVE(act),
		.CAPTURE_DONE(done), .TRIGGERED(trig));
	recorder_host host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
		logic e;
		logic ok;
		host.xfer(w, a, d, got, e, ok);
		chk({31'h0, e}, {31'h0, er});
		if (ok !== 1'b1) begin
			error_cnt++;
			print_verdict();
		end
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
		bus(1'b0, a, 32'h0, er);
		chk(got, e);
	endtask : rd

	task automatic cfg(input logic [3:0] c, input logic [15:0] th, input logic [6:0] pct,
		input logic [15:0] dec, input logic [8:0] cnt);
		bus(1'b1, recorder_pkg::OFF_CONTROL, {28'h0, c}, 1'b0);
		bus(1'b1, recorder_pkg::OFF_THRESHOLD, {16'h0, th}, 1'b0);
		bus(1'b1, recorder_pkg::OFF_PERCENT, {25'h0, pct}, 1'b0);
		bus(1'b1, recorder_pkg::OFF_DECIMATION, {16'h0, dec}, 1'b0);
		bus(1'b1, recorder_pkg::OFF_COUNT, {23'h0, cnt}, 1'b0);
		bus(1'b1, recorder_pkg::OFF_COMMAND, 32'h1, 1'b0);
	endtask : cfg

	// Bounded wait for the trigger flag or, with d set, for capture done.
	task automatic await(input logic d, input int ticks);
		int n;
		n = 0;
		// The flags move one edge after the arm write, so the first look waits for it.
		@(posedge clock);
		while ((d ? done : trig) !== 1'b1 && n < ticks * T) begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, d ? done : trig}, 32'h1);
		if (n >= ticks * T) begin
			print_verdict();
		end
	endtask : await

	task automatic pair(input logic [31:0] step);
		bus(1'b0, recorder_pkg::OFF_READOUT, 32'h0, 1'b0);
		first = got;
		rd(recorder_pkg::OFF_READOUT, (first + step) % 32'ha);
		@(posedge clock);
		chk({31'h0, done}, 32'h0);
	endtask : pair

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rd(recorder_pkg::OFF_CONTROL, 32'h0);
		rd(recorder_pkg::OFF_DECIMATION, 32'h1);
		rd(recorder_pkg::OFF_COUNT, 32'h100);
		rd(recorder_pkg::OFF_STATUS, 32'h0);
		rd(8'h20, 32'h0, 1'b1);
		$display("registers done");
		cfg(4'h8, 16'h0, 7'd50, 16'h1, 9'h2);
		repeat (4) @(posedge clock);
		chk({31'h0, trig}, 32'h1);
		await(1'b1, 4);
		pair(32'h1);
		cfg(4'h8, 16'h0, 7'd0, 16'h2, 9'h2);
		await(1'b1, 6);
		pair(32'h2);
		$display("immediate done");
		cfg(4'h7, 16'h7fff, 7'd0, 16'h1, 9'h1);
		rd(recorder_pkg::OFF_CONTROL, 32'h7);
		await(1'b0, 2);
		cfg(4'h3, 16'h0, 7'd0, 16'h1, 9'h1);
		repeat (3 * T) @(posedge clock);
		chk({31'h0, trig}, 32'h0);
		act <= 1'b0;
		await(1'b0, 2);
		$display("boolean done");
		cfg(4'he, 16'h3, 7'd0, 16'h1, 9'h1);
		await(1'b1, 12);
		rd(recorder_pkg::OFF_READOUT, 32'h3);
		cfg(4'ha, 16'h3, 7'd0, 16'h1, 9'h1);
		await(1'b1, 12);
		rd(recorder_pkg::OFF_READOUT, 32'h0);
		cfg(4'h6, 16'h0, 7'd0, 16'h1, 9'h1);
		repeat (3 * T) @(posedge clock);
		chk({31'h0, trig}, 32'h0);
		fb <= 16'h0040;
		await(1'b1, 3);
		rd(recorder_pkg::OFF_READOUT, 32'h40);
		$display("threshold done");
		cfg(4'he, 16'h3, 7'd50, 16'h1, 9'h4);
		await(1'b1, 14);
		rd(recorder_pkg::OFF_STATUS, 32'h0004_000c);
		rd(recorder_pkg::OFF_READOUT, 32'h1);
		rd(recorder_pkg::OFF_READOUT, 32'h2);
		rd(recorder_pkg::OFF_READOUT, 32'h3);
		rd(recorder_pkg::OFF_READOUT, 32'h4);
		$display("pretrigger done");
		cfg(4'h1, 16'h0, 7'd0, 16'h1, 9'h1);
		repeat (2 * T) @(posedge clock);
		chk({31'h0, trig}, 32'h0);
		rd(recorder_pkg::OFF_STATUS, 32'h1);
		@(posedge clock);
		chk({31'h0, trig}, 32'h1);
		$display("command done");
		print_verdict();
	end
endmodule : tb_sample_recorder_trigger

bind sample_recorder_trigger recorder_assertions chk (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .CURRENT_FEEDBACK_VALUE(CURRENT_FEEDBACK_VALUE),
	.DRIVE_ACTIVE(DRIVE_ACTIVE), .CAPTURE_DONE(CAPTURE_DONE), .TRIGGERED(TRIGGERED));
